// *** rtl/slmn_pkg.sv ***
package slmn_pkg;

  // clock and line rates
  localparam int          CLK_HZ        = 25_000_000;
  localparam int          BAUD_SLOW     = 9600;
  localparam int          BAUD_FAST     = 19200;
  localparam logic [11:0] BIT_CYC_SLOW  = 12'(CLK_HZ / BAUD_SLOW);
  localparam logic [11:0] BIT_CYC_FAST  = 12'(CLK_HZ / BAUD_FAST);
  localparam logic [3:0]  STOP_BIT      = 4'h9;

  // addressing
  localparam logic [6:0]  ID_HOST       = 7'h00;
  localparam logic [6:0]  ID_MIN        = 7'h01;
  localparam logic [6:0]  ID_MAX        = 7'h62;
  localparam logic [6:0]  ID_GLOBAL     = 7'h63;
  localparam logic [6:0]  ID_RESET      = 7'h01;

  // frame characters
  localparam logic [7:0]  CH_START      = 8'h2A;
  localparam logic [7:0]  CH_END        = 8'h0D;
  localparam logic [7:0]  CH_ASSIGN     = 8'h23;
  localparam logic [7:0]  CH_ZERO       = 8'h30;
  localparam logic [7:0]  CH_TEN        = 8'h0A;

  // output modes that stream by themselves
  localparam logic [3:0]  MODE_CONT_A   = 4'h2;
  localparam logic [3:0]  MODE_CONT_B   = 4'h3;
  localparam logic [3:0]  MODE_CONT_C   = 4'hC;

  // forward queue and header lengths
  localparam logic [3:0]  Q_DEPTH       = 4'h8;
  localparam logic [2:0]  FWD_HDR_LEN   = 3'h4;
  localparam logic [2:0]  OWN_HDR_LEN   = 3'h5;

  typedef enum logic [2:0] {
    SLMN_HUNT, SLMN_H1, SLMN_H2, SLMN_H3, SLMN_BODY
  } slmn_frame_type;

  typedef enum logic [1:0] {
    SLMN_IDLE, SLMN_FWD, SLMN_LOCAL, SLMN_WAIT
  } slmn_owner_type;

  // two ascii digits to a binary unit number
  function automatic logic [6:0] slmn_dig2bin(input logic [7:0] t,
                                              input logic [7:0] o);
    logic [7:0] v;
    v = 8'((t - CH_ZERO) * CH_TEN) + 8'(o - CH_ZERO);
    return v[6:0];
  endfunction

  function automatic logic [7:0] slmn_tens(input logic [6:0] id);
    return CH_ZERO + {4'h0, 4'(id / 7'h0A)};
  endfunction

  function automatic logic [7:0] slmn_ones(input logic [6:0] id);
    return CH_ZERO + {4'h0, 4'(id % 7'h0A)};
  endfunction

  // a node may only hold an individually addressable number
  function automatic logic slmn_id_ok(input logic [6:0] id);
    return (id >= ID_MIN) && (id <= ID_MAX);
  endfunction

endpackage

// *** rtl/slmn_uart_tx.sv ***
module slmn_uart_tx
  import slmn_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [11:0] bit_cyc,
  input  wire logic        hold_oe,
  input  wire logic [7:0]  data,
  input  wire logic        valid,
  output logic             ready,
  output logic             line,
  output logic             oe
);

  logic        busy_r, busy_nxt;
  logic [8:0]  sh_r, sh_nxt;
  logic [3:0]  bits_r, bits_nxt;
  logic [11:0] cnt_r, cnt_nxt;
  logic        line_r, line_nxt;
  logic        oe_r, oe_nxt;
  logic        ready_r, ready_nxt;

  // 8N1 shifter; the bit timer doubles as the baud enable
  always_comb begin
    busy_nxt  = busy_r;
    sh_nxt    = sh_r;
    bits_nxt  = bits_r;
    cnt_nxt   = cnt_r;
    line_nxt  = line_r;
    ready_nxt = ready_r;
    if (!busy_r) begin
      line_nxt = 1'b1;
      if (valid && ready_r) begin
        busy_nxt  = 1'b1;
        sh_nxt    = {1'b1, data};
        line_nxt  = 1'b0;                 // start bit
        cnt_nxt   = 12'(bit_cyc - 12'h001);
        bits_nxt  = 4'h0;
        ready_nxt = 1'b0;
      end
    end else if (cnt_r != 12'h000) begin
      cnt_nxt = 12'(cnt_r - 12'h001);
    end else begin
      cnt_nxt = 12'(bit_cyc - 12'h001);
      if (bits_r == STOP_BIT) begin
        busy_nxt  = 1'b0;
        ready_nxt = 1'b1;
      end else begin
        line_nxt = sh_r[0];
        sh_nxt   = {1'b1, sh_r[8:1]};
        bits_nxt = bits_r + 4'h1;
      end
    end
    // driver released as soon as the stop bit ends, unless hold_oe keeps it on
    oe_nxt = busy_nxt | hold_oe;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      busy_r  <= 1'b0;
      sh_r    <= 9'h1FF;
      bits_r  <= 4'h0;
      cnt_r   <= 12'h000;
      line_r  <= 1'b1;
      oe_r    <= 1'b0;
      ready_r <= 1'b1;
    end else begin
      busy_r  <= busy_nxt;
      sh_r    <= sh_nxt;
      bits_r  <= bits_nxt;
      cnt_r   <= cnt_nxt;
      line_r  <= line_nxt;
      oe_r    <= oe_nxt;
      ready_r <= ready_nxt;
    end
  end

  assign ready = ready_r;
  assign line  = line_r;
  assign oe    = oe_r;

endmodule // slmn_uart_tx

// *** rtl/slmn_node.sv ***
// Behaviour
// - unit numbers 1 to 98 are individually addressable
// - bus number assignment taken by every listener
// - ring assign frame numbers nodes in turn
// - bus secondary speaks only when commanded or streaming
// - bus driver off whenever not sending
// - own command executed, others forwarded downstream
// - global command executed and also forwarded
// - replies go to host, forwarded by all
// - forwarding ahead of own reply at every frame boundary
// - global echo precedes the node replies
// - stream command volatile, output mode persistent
module slmn_node
  import slmn_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       rx_line,
  input  wire logic       ring_mode,
  input  wire logic       baud_fast,
  input  wire logic [6:0] unit_id_strap,
  input  wire logic       id_set_valid,
  input  wire logic [6:0] id_set_value,
  input  wire logic       stream_start,
  input  wire logic       stream_stop,
  input  wire logic [3:0] output_mode_setting,
  input  wire logic [7:0] rsp_data,
  input  wire logic       rsp_valid,
  input  wire logic       rsp_last,
  output logic [7:0]      cmd_data,
  output logic            cmd_valid,
  output logic            cmd_last,
  output logic            rsp_ready,
  output logic [6:0]      unit_id,
  output logic            continuous_active,
  output logic            tx_line,
  output logic            tx_oe
);

  logic [11:0] bit_cyc;
  logic        tx_valid, tx_ready, pop, push, local_done;
  logic [7:0]  tx_data, push_data;

  // one rate for the whole network, chosen by the integrator
  assign bit_cyc = baud_fast ? BIT_CYC_FAST : BIT_CYC_SLOW;

  // ---------------- receiver ----------------
  logic        rx_s1_r, rx_s2_r;
  logic        rx_busy_r, rx_busy_nxt;
  logic [11:0] rx_cnt_r, rx_cnt_nxt;
  logic [3:0]  rx_bit_r, rx_bit_nxt;
  logic [7:0]  rx_sh_r, rx_sh_nxt;
  logic        rx_stb_r, rx_stb_nxt;

  // sample mid-bit; a start bit that is high again is a glitch
  always_comb begin
    rx_busy_nxt = rx_busy_r;
    rx_cnt_nxt  = rx_cnt_r;
    rx_bit_nxt  = rx_bit_r;
    rx_sh_nxt   = rx_sh_r;
    rx_stb_nxt  = 1'b0;
    if (!rx_busy_r) begin
      if (!rx_s2_r) begin
        rx_busy_nxt = 1'b1;
        rx_cnt_nxt  = {1'b0, bit_cyc[11:1]};
        rx_bit_nxt  = 4'h0;
      end
    end else if (rx_cnt_r != 12'h000) begin
      rx_cnt_nxt = 12'(rx_cnt_r - 12'h001);
    end else begin
      rx_cnt_nxt = 12'(bit_cyc - 12'h001);   // same bit period as the sender
      rx_bit_nxt = rx_bit_r + 4'h1;
      if (rx_bit_r == 4'h0) begin
        rx_busy_nxt = ~rx_s2_r;
      end else if (rx_bit_r < STOP_BIT) begin
        rx_sh_nxt = {rx_s2_r, rx_sh_r[7:1]};
      end else begin
        rx_busy_nxt = 1'b0;
        rx_stb_nxt  = rx_s2_r;          // framing error drops the byte
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rx_s1_r   <= 1'b1;
      rx_s2_r   <= 1'b1;
      rx_busy_r <= 1'b0;
      rx_cnt_r  <= 12'h000;
      rx_bit_r  <= 4'h0;
      rx_sh_r   <= 8'h00;
      rx_stb_r  <= 1'b0;
    end else begin
      rx_s1_r   <= rx_line;
      rx_s2_r   <= rx_s1_r;
      rx_busy_r <= rx_busy_nxt;
      rx_cnt_r  <= rx_cnt_nxt;
      rx_bit_r  <= rx_bit_nxt;
      rx_sh_r   <= rx_sh_nxt;
      rx_stb_r  <= rx_stb_nxt;
    end
  end

  // ---------------- frame parser ----------------
  slmn_frame_type fr_r, fr_nxt;
  logic [7:0]  h1_r, h1_nxt, h2_r, h2_nxt;
  logic        exec_r, exec_nxt, fwd_r, fwd_nxt;
  logic [7:0]  hdr_r [4];
  logic [7:0]  hdr_nxt [4];
  logic [2:0]  dump_r, dump_nxt;
  logic [6:0]  id_r, id_nxt, dest, newid;
  logic        first_r, permit_r, permit_nxt, stream_r, stream_nxt;
  logic        cont_r, cont_nxt;
  logic [7:0]  cmd_data_r, cmd_data_nxt;
  logic        cmd_valid_r, cmd_valid_nxt, cmd_last_r, cmd_last_nxt;

  // header held three bytes so the route is known before anything leaves
  always_comb begin
    fr_nxt        = fr_r;
    h1_nxt        = h1_r;
    h2_nxt        = h2_r;
    exec_nxt      = exec_r;
    fwd_nxt       = fwd_r;
    hdr_nxt       = hdr_r;
    dump_nxt      = dump_r;
    id_nxt        = id_r;
    permit_nxt    = permit_r;
    cmd_data_nxt  = rx_sh_r;
    cmd_valid_nxt = 1'b0;
    cmd_last_nxt  = 1'b0;
    push          = 1'b0;
    push_data     = rx_sh_r;
    dest          = slmn_dig2bin(h1_r, h2_r);
    newid         = slmn_dig2bin(h2_r, rx_sh_r);
    if (first_r && slmn_id_ok(unit_id_strap)) begin
      id_nxt = unit_id_strap;
    end
    if (id_set_valid && slmn_id_ok(id_set_value)) begin
      id_nxt = id_set_value;          // whoever hears it takes it
    end
    if (dump_r != 3'h0) begin
      push      = 1'b1;
      push_data = hdr_r[2'(FWD_HDR_LEN - dump_r)];
      dump_nxt  = dump_r - 3'h1;
    end
    if (rx_stb_r) begin
      case (fr_r)
        SLMN_HUNT: begin
          if (rx_sh_r == CH_START) begin
            fr_nxt = SLMN_H1;
          end
        end
        SLMN_H1: begin
          h1_nxt = rx_sh_r;
          fr_nxt = (rx_sh_r == CH_END) ? SLMN_HUNT : SLMN_H2;
        end
        SLMN_H2: begin
          h2_nxt = rx_sh_r;
          fr_nxt = (rx_sh_r == CH_END) ? SLMN_HUNT : SLMN_H3;
        end
        SLMN_H3: begin
          fr_nxt = (rx_sh_r == CH_END) ? SLMN_HUNT : SLMN_BODY;
          if (h1_r == CH_ASSIGN) begin
            exec_nxt = 1'b0;
            fwd_nxt  = ring_mode && (rx_sh_r != CH_END);
            if (slmn_id_ok(newid)) begin
              id_nxt = newid;
            end
            // next node downstream gets the following number
            hdr_nxt[0] = CH_START;
            hdr_nxt[1] = CH_ASSIGN;
            hdr_nxt[2] = slmn_tens(7'(newid + 7'h01));
            hdr_nxt[3] = slmn_ones(7'(newid + 7'h01));
          end else begin
            // own or global number is executed
            exec_nxt = (dest == id_r) || (dest == ID_GLOBAL);
            // anything not solely ours travels on, host replies too
            fwd_nxt  = ring_mode && (dest != id_r);
            hdr_nxt[0] = CH_START;
            hdr_nxt[1] = h1_r;
            hdr_nxt[2] = h2_r;
            hdr_nxt[3] = rx_sh_r;
            cmd_valid_nxt = exec_nxt;
            cmd_last_nxt  = exec_nxt && (rx_sh_r == CH_END);
          end
          if (fwd_nxt) begin
            dump_nxt = FWD_HDR_LEN;
          end
          // frame ended inside its header: nothing more to pass on
          if (rx_sh_r == CH_END) begin
            fwd_nxt = 1'b0;
          end
        end
        default: begin
          cmd_valid_nxt = exec_r;
          cmd_last_nxt  = exec_r && (rx_sh_r == CH_END);
          if (fwd_r) begin
            push      = 1'b1;
            push_data = rx_sh_r;
          end
          if (rx_sh_r == CH_END) begin
            fr_nxt  = SLMN_HUNT;
            fwd_nxt = 1'b0;
          end
        end
      endcase
    end
    // permission to answer; a new command wins over a finished reply
    if (local_done) begin
      permit_nxt = 1'b0;
    end
    if (cmd_valid_nxt && cmd_last_nxt) begin
      permit_nxt = 1'b1;
    end
    // stream command forgotten at reset, output mode is not
    stream_nxt = stream_start ? 1'b1 : (stream_stop ? 1'b0 : stream_r);
    cont_nxt   = stream_nxt || (output_mode_setting == MODE_CONT_A) ||
                 (output_mode_setting == MODE_CONT_B) ||
                 (output_mode_setting == MODE_CONT_C);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      fr_r        <= SLMN_HUNT;
      h1_r        <= 8'h00;
      h2_r        <= 8'h00;
      exec_r      <= 1'b0;
      fwd_r       <= 1'b0;
      hdr_r       <= '{default: 8'h00};
      dump_r      <= 3'h0;
      id_r        <= ID_RESET;
      first_r     <= 1'b1;
      permit_r    <= 1'b0;
      stream_r    <= 1'b0;
      cont_r      <= 1'b0;
      cmd_data_r  <= 8'h00;
      cmd_valid_r <= 1'b0;
      cmd_last_r  <= 1'b0;
    end else begin
      fr_r        <= fr_nxt;
      h1_r        <= h1_nxt;
      h2_r        <= h2_nxt;
      exec_r      <= exec_nxt;
      fwd_r       <= fwd_nxt;
      hdr_r       <= hdr_nxt;
      dump_r      <= dump_nxt;
      id_r        <= id_nxt;
      first_r     <= 1'b0;
      permit_r    <= permit_nxt;
      stream_r    <= stream_nxt;
      cont_r      <= cont_nxt;
      cmd_data_r  <= cmd_data_nxt;
      cmd_valid_r <= cmd_valid_nxt;
      cmd_last_r  <= cmd_last_nxt;
    end
  end

  // ---------------- forward queue ----------------
  logic [7:0] q_r [8];
  logic [7:0] q_nxt [8];
  logic [2:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [3:0] qc_r, qc_nxt;

  // a full queue drops; only a long own reply holding the transmitter can cause that
  always_comb begin
    q_nxt  = q_r;
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    qc_nxt = qc_r;
    if (push && (qc_r != Q_DEPTH)) begin
      q_nxt[wp_r] = push_data;
      wp_nxt      = wp_r + 3'h1;
      qc_nxt      = qc_nxt + 4'h1;
    end
    if (pop) begin
      rp_nxt = rp_r + 3'h1;
      qc_nxt = qc_nxt - 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      q_r  <= '{default: 8'h00};
      wp_r <= 3'h0;
      rp_r <= 3'h0;
      qc_r <= 4'h0;
    end else begin
      q_r  <= q_nxt;
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      qc_r <= qc_nxt;
    end
  end

  // ---------------- transmit arbiter ----------------
  slmn_owner_type own_r, own_nxt;
  logic [2:0] lh_r, lh_nxt;
  logic       rsp_ready_r, rsp_ready_nxt;

  // own reply header always addresses the host
  function automatic logic [7:0] own_hdr(input logic [2:0] i,
                                         input logic [6:0] id);
    case (i)
      3'h0:    return CH_START;
      3'h1:    return slmn_tens(ID_HOST);
      3'h2:    return slmn_ones(ID_HOST);
      3'h3:    return slmn_tens(id);
      default: return slmn_ones(id);
    endcase
  endfunction

  // frames are never interleaved; forwarding wins each boundary
  always_comb begin
    own_nxt       = own_r;
    lh_nxt        = lh_r;
    tx_valid      = 1'b0;
    tx_data       = q_r[rp_r];
    pop           = 1'b0;
    local_done    = 1'b0;
    rsp_ready_nxt = 1'b0;
    case (own_r)
      SLMN_IDLE: begin
        if ((qc_r != 4'h0) || fwd_r || (dump_r != 3'h0)) begin
          own_nxt = SLMN_FWD;
        end else if (rsp_valid && (permit_r || cont_r)) begin
          own_nxt = SLMN_LOCAL;
          lh_nxt  = 3'h0;
        end
      end
      SLMN_FWD: begin
        tx_valid = qc_r != 4'h0;
        pop      = tx_valid && tx_ready;
        if ((qc_r == 4'h0) && !fwd_r && (dump_r == 3'h0)) begin
          own_nxt = SLMN_IDLE;
        end
      end
      SLMN_LOCAL: begin
        if (lh_r < OWN_HDR_LEN) begin
          tx_valid = 1'b1;
          tx_data  = own_hdr(lh_r, id_r);
          if (tx_ready) begin
            lh_nxt = lh_r + 3'h1;
          end
        end else begin
          tx_valid = rsp_valid;
          tx_data  = rsp_data;
          if (rsp_valid && tx_ready) begin
            rsp_ready_nxt = 1'b1;
            if (rsp_last) begin
              local_done = 1'b1;
              own_nxt    = SLMN_WAIT;
            end
          end
        end
      end
      default: begin
        own_nxt = SLMN_IDLE;   // lets the source retire its last byte
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      own_r       <= SLMN_IDLE;
      lh_r        <= 3'h0;
      rsp_ready_r <= 1'b0;
    end else begin
      own_r       <= own_nxt;
      lh_r        <= lh_nxt;
      rsp_ready_r <= rsp_ready_nxt;
    end
  end

  // ring link is point to point, so its driver may stay on
  slmn_uart_tx u_tx (
    .clk     (clk),
    .reset   (reset),
    .bit_cyc (bit_cyc),
    .hold_oe (ring_mode),
    .data    (tx_data),
    .valid   (tx_valid),
    .ready   (tx_ready),
    .line    (tx_line),
    .oe      (tx_oe)
  );

  assign cmd_data          = cmd_data_r;
  assign cmd_valid         = cmd_valid_r;
  assign cmd_last          = cmd_last_r;
  assign rsp_ready         = rsp_ready_r;
  assign unit_id           = id_r;
  assign continuous_active = cont_r;

endmodule // slmn_node

// *** tb/slmn_node_chk.sv ***
module slmn_node_chk
  import slmn_pkg::*;
(
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       rx_line,
  input wire logic       ring_mode,
  input wire logic       baud_fast,
  input wire logic [6:0] unit_id_strap,
  input wire logic       id_set_valid,
  input wire logic [6:0] id_set_value,
  input wire logic       stream_start,
  input wire logic       stream_stop,
  input wire logic [3:0] output_mode_setting,
  input wire logic [7:0] rsp_data,
  input wire logic       rsp_valid,
  input wire logic       rsp_last,
  input wire logic [7:0] cmd_data,
  input wire logic       cmd_valid,
  input wire logic       cmd_last,
  input wire logic       rsp_ready,
  input wire logic [6:0] unit_id,
  input wire logic       continuous_active,
  input wire logic       tx_line,
  input wire logic       tx_oe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  cmd_end_a: assert property (
    cmd_last |-> cmd_valid && cmd_data == CH_END)
    else $error("cmd_last without carriage return");
  cmd_pulse_a: assert property (cmd_valid |=> !cmd_valid)
    else $error("cmd_valid longer than one cycle");
  ring_drive_a: assert property (ring_mode |=> tx_oe)
    else $error("ring driver not held on");
  idle_release_a: assert property (!ring_mode && !tx_oe |-> tx_line)
    else $error("released line not idle high");
  start_driven_a: assert property (!tx_line |-> tx_oe)
    else $error("line low while driver off");
  id_range_a: assert property (unit_id >= ID_MIN && unit_id <= ID_MAX)
    else $error("unit id outside 1 to 98");
  id_load_a: assert property (id_set_valid && id_set_value >= ID_MIN
    && id_set_value <= ID_MAX |=> unit_id == $past(id_set_value))
    else $error("unit id not loaded");
  id_refuse_a: assert property (id_set_valid && (id_set_value > ID_MAX
    || id_set_value == 7'h00) |=> $stable(unit_id))
    else $error("bad unit id taken");
  mode_cont_a: assert property (output_mode_setting == 4'h2
    || output_mode_setting == 4'h3 || output_mode_setting == 4'hC
    |-> ##[1:2] continuous_active)
    else $error("persistent mode not streaming");
endmodule // slmn_node_chk

bind slmn_node slmn_node_chk u_slmn_node_chk (
  .clk(clk), .reset(reset), .rx_line(rx_line), .ring_mode(ring_mode),
  .baud_fast(baud_fast), .unit_id_strap(unit_id_strap),
  .id_set_valid(id_set_valid), .id_set_value(id_set_value),
  .stream_start(stream_start), .stream_stop(stream_stop),
  .output_mode_setting(output_mode_setting), .rsp_data(rsp_data),
  .rsp_valid(rsp_valid), .rsp_last(rsp_last), .cmd_data(cmd_data),
  .cmd_valid(cmd_valid), .cmd_last(cmd_last), .rsp_ready(rsp_ready),
  .unit_id(unit_id), .continuous_active(continuous_active),
  .tx_line(tx_line), .tx_oe(tx_oe));

// *** tb/slmn_host_model.sv ***
module slmn_host_model
  import slmn_pkg::*;
(
  input  wire logic clk,
  input  wire logic tx_line,
  input  wire logic tx_oe,
  output logic      rx_line
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] got_q[$];
  logic       wire_lvl;

  // released pair floats high through the terminator
  assign wire_lvl = tx_oe ? tx_line : 1'b1;

  // own pair to the node, so the host may drive it all the time
  initial rx_line = 1'b1;

  // one shared rate for the whole network, no faster than a ring allows
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx_line = f[i];
      repeat (int'(BIT_CYC_FAST)) @(negedge clk);
    end
  endtask

  // mid-bit sampling; a byte whose stop bit reads low is thrown away
  always begin : rx_proc
    logic [7:0] b;
    @(negedge wire_lvl);
    repeat (int'(BIT_CYC_FAST) / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (int'(BIT_CYC_FAST)) @(posedge clk);
      b[i] = wire_lvl;
    end
    repeat (int'(BIT_CYC_FAST)) @(posedge clk);
    if (wire_lvl) got_q.push_back(b);
  end
endmodule // slmn_host_model

// *** tb/test_serial_loop_multidrop_node.sv ***
module test_serial_loop_multidrop_node
  import slmn_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ns;

  logic       clk = 1'b0;
  logic       reset = 1'b1;
  logic       rx_line;
  logic       ring_mode = 1'b0;
  logic       baud_fast = 1'b1;
  logic [6:0] unit_id_strap = 7'h05;
  logic       id_set_valid = 1'b0;
  logic [6:0] id_set_value = 7'h00;
  logic       stream_start = 1'b0;
  logic       stream_stop = 1'b0;
  logic [3:0] output_mode_setting = 4'h0;
  logic [7:0] rsp_data = 8'h00;
  logic       rsp_valid = 1'b0;
  logic       rsp_last = 1'b0;
  logic [7:0] cmd_data;
  logic       cmd_valid;
  logic       cmd_last;
  logic       rsp_ready;
  logic [6:0] unit_id;
  logic       continuous_active;
  logic       tx_line;
  logic       tx_oe;
  logic [8:0] cmd_q[$];
  int         n_fail = 0;
  int         n_checks = 0;
  int         cycles = 0;

  always #20 clk = ~clk;

  slmn_node u_slmn_node (.clk(clk), .reset(reset), .rx_line(rx_line),
    .ring_mode(ring_mode), .baud_fast(baud_fast),
    .unit_id_strap(unit_id_strap), .id_set_valid(id_set_valid),
    .id_set_value(id_set_value), .stream_start(stream_start),
    .stream_stop(stream_stop), .output_mode_setting(output_mode_setting),
    .rsp_data(rsp_data), .rsp_valid(rsp_valid), .rsp_last(rsp_last),
    .cmd_data(cmd_data), .cmd_valid(cmd_valid), .cmd_last(cmd_last),
    .rsp_ready(rsp_ready), .unit_id(unit_id),
    .continuous_active(continuous_active), .tx_line(tx_line),
    .tx_oe(tx_oe));

  slmn_host_model u_slmn_host_model (.clk(clk), .tx_line(tx_line),
    .tx_oe(tx_oe), .rx_line(rx_line));

  // executed bytes, tagged with the last flag
  always @(posedge clk)
    if (cmd_valid === 1'b1) cmd_q.push_back({cmd_last, cmd_data});

  // hang guard; the ring echo needs about 104k cycles at 19200 baud
  always @(posedge clk) begin
    cycles++;
    if (cycles == 112000) begin
      n_fail++;
      wrap_up();
    end
  end

  task automatic check(input string what, input logic [8:0] exp,
                       input logic [8:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // power cycle stand-in; strap loads on the first edge after release
  task automatic do_reset();
    reset = 1'b1;
    repeat (16) @(negedge clk);
    reset = 1'b0;
    repeat (3) @(negedge clk);
  endtask

  task automatic t_after_reset();
    check("oe", 9'h0, {8'h0, tx_oe});
    check("line", 9'h1, {8'h0, tx_line});
    check("strap id", 9'h5, {2'h0, unit_id});
  endtask

  // in-range numbers are taken, 0 and 99 refused
  task automatic t_ids();
    logic [6:0] v[4];
    logic [6:0] e[4];
    v = '{7'h62, 7'h63, 7'h00, 7'h05};
    e = '{7'h62, 7'h62, 7'h62, 7'h05};
    for (int i = 0; i < 4; i++) begin
      id_set_value = v[i];
      id_set_valid = 1'b1;
      @(negedge clk);
      id_set_valid = 1'b0;
      @(negedge clk);
      check("unit id", {2'h0, e[i]}, {2'h0, unit_id});
    end
  endtask

  // only modes 2, 3 and 12 stream; streaming command dies at reset
  task automatic t_modes();
    for (int m = 0; m < 16; m++) begin
      output_mode_setting = 4'(m);
      repeat (3) @(negedge clk);
      check("mode cont", {8'h0, m == 2 || m == 3 || m == 12},
            {8'h0, continuous_active});
    end
    output_mode_setting = 4'h0;
    stream_start = 1'b1;
    @(negedge clk);
    stream_start = 1'b0;
    repeat (2) @(negedge clk);
    check("stream on", 9'h1, {8'h0, continuous_active});
    stream_stop = 1'b1;
    @(negedge clk);
    stream_stop = 1'b0;
    repeat (2) @(negedge clk);
    check("stream off", 9'h0, {8'h0, continuous_active});
    stream_start = 1'b1;
    @(negedge clk);
    stream_start = 1'b0;
    do_reset();
    check("stream reset", 9'h0, {8'h0, continuous_active});
    output_mode_setting = 4'hC;
    do_reset();
    check("mode kept", 9'h1, {8'h0, continuous_active});
    output_mode_setting = 4'h0;
    repeat (3) @(negedge clk);
  endtask

  // uncommanded secondary keeps its reply and its driver off
  task automatic t_bus_quiet();
    int bad;
    bad = 0;
    rsp_data = 8'h5A;
    rsp_last = 1'b1;
    rsp_valid = 1'b1;
    repeat (3000) begin
      @(negedge clk);
      if (tx_oe !== 1'b0 || rsp_ready !== 1'b0) bad++;
    end
    rsp_valid = 1'b0;
    check("bus quiet", 9'h0, 9'(bad));
  endtask

  // global frame: run, echo unchanged, own reply only after the echo
  task automatic t_ring_global();
    logic [7:0] fr[4];
    int         rdy;
    int         k;
    fr = '{8'h2A, 8'h39, 8'h39, 8'h0D};
    rdy = 0;
    k = 0;
    ring_mode = 1'b1;
    do_reset();
    u_slmn_host_model.got_q.delete();
    cmd_q.delete();
    rsp_data = 8'h51;
    rsp_last = 1'b1;
    rsp_valid = 1'b1;
    for (int i = 0; i < 4; i++) u_slmn_host_model.send_byte(fr[i]);
    // host waits for the whole echo before anything else
    while (u_slmn_host_model.got_q.size() < 4) begin
      @(negedge clk);
      if (rsp_ready === 1'b1) rdy++;
    end
    for (int i = 0; i < 4; i++)
      check("echo", {1'b0, fr[i]},
            {1'b0, u_slmn_host_model.got_q[i]});
    check("early reply", 9'h0, 9'(rdy));
    // own frame starts about half a bit after the echo is taken
    while (tx_line === 1'b1 && k < 2000) begin
      @(negedge clk);
      k++;
    end
    check("reply start", 9'h0, {8'h0, tx_line});
    check("cmd count", 9'h1, 9'(cmd_q.size()));
    check("cmd end", 9'h10D, cmd_q[0]);
    rsp_valid = 1'b0;
  endtask

  initial begin
    do_reset();
    t_after_reset();
    t_ids();
    t_modes();
    t_bus_quiet();
    t_ring_global();
    wrap_up();
  end
endmodule // test_serial_loop_multidrop_node
